/* hdl/pfcs_cycle.sv */
/*
 one bus cycle on the flash pins: a write strobe or a timed read.
 assumes the flash data pins are returned through a two-stage synchroniser.
*/
`timescale 1ns/1ns
`default_nettype none
module pfcs_cycle
   import pfcs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start, // one-cycle request
   input wire logic is_write, // write when high, read when low
   input wire pfcs_pkg::pfcs_cyc_t cyc, // address and write data
   input wire logic [7:0] dq_sync, // synchronised data pins
   output logic done, // one-cycle end pulse
   output logic [7:0] rdata, // captured read data
   output logic [18:0] addr_o, // address pins
   output logic [7:0] dq_o, // data pins out
   output logic dq_oe, // data drive enable
   output logic ce_n, // chip select, low active
   output logic oe_n, // output gate, low active
   output logic we_n // write strobe, low active
);
   // ----------------------------------------
   // cycle sequencer
   // ----------------------------------------
   typedef enum logic [1:0] {PFCS_C_IDLE, PFCS_C_SETUP, PFCS_C_ACT, PFCS_C_HOLD} pfcs_cst_t;
   pfcs_cst_t st_q;
   logic [3:0] cnt_q; // phase length counter
   logic wr_q; // kind of current cycle
   // read waits two extra cycles for the synchroniser
   wire [3:0] act_len = wr_q ? 4'(PFCS_STROBE_CYC) : 4'(PFCS_READ_CYC + 2);
   wire act_end = (st_q == PFCS_C_ACT) && (cnt_q == act_len - 4'h1);

   // phase advance and pin drive; strobe width far above the 5 ns glitch limit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= PFCS_C_IDLE;
         cnt_q <= 4'h0;
         wr_q <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
         addr_o <= 19'h00000;
         dq_o <= 8'h00;
         dq_oe <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
      end else begin
         done <= 1'b0;
         unique case (st_q)
            PFCS_C_IDLE: if (start) begin
               // address first, strobes high; oe stays high on writes [R05] [R18]
               st_q <= PFCS_C_SETUP;
               wr_q <= is_write;
               addr_o <= cyc.addr;
               dq_o <= cyc.data;
               dq_oe <= is_write;
            end
            PFCS_C_SETUP: begin
               st_q <= PFCS_C_ACT;
               cnt_q <= 4'h0;
               ce_n <= 1'b0;
               we_n <= ~wr_q; // [R04] [R18] [R21]
               oe_n <= wr_q; // [R17]
            end
            PFCS_C_ACT: begin
               cnt_q <= cnt_q + 4'h1;
               if (act_end) begin
                  // rising strobe latches data; one hold cycle follows
                  st_q <= PFCS_C_HOLD;
                  we_n <= 1'b1;
                  oe_n <= 1'b1;
                  ce_n <= 1'b1;
                  rdata <= dq_sync;
               end
            end
            PFCS_C_HOLD: begin
               st_q <= PFCS_C_IDLE;
               dq_oe <= 1'b0;
               done <= 1'b1;
            end
         endcase
      end
   end

   // the phase counter is four bits wide; refuse a read length it cannot hold or a zero strobe
   if (PFCS_STROBE_CYC < 1 || PFCS_READ_CYC + 2 > 15) begin : g_bad_timing
      $error("bad cycle timing");
   end

   strobe_width_a: assert property (@(posedge clk) disable iff (rst) // [R04]
      $fell(we_n) |-> !we_n [*2] ##1 we_n) else $error("write strobe width wrong");
   write_gate_a: assert property (@(posedge clk) disable iff (rst) // [R05]
      !we_n |-> !ce_n && oe_n && dq_oe) else $error("write without gating");
   read_gate_a: assert property (@(posedge clk) disable iff (rst) // [R17]
      !oe_n |-> !ce_n && we_n && !dq_oe) else $error("read while driving");
endmodule // pfcs_cycle
`default_nettype wire

/* hdl/pfcs_host.sv */
/*
 host controller for a byte-wide parallel flash: issues unlock command
 sequences, polls the alternating status bit, reads array and id codes.
 assumes the flash pins are asynchronous; data pins come back unsynchronised.
*/
// Operation
// [R01] status bit six alternates while busy
// [R02] alternation stops when the operation finishes
// [R03] polling starts after fourth or sixth strobe
// [R04] strobes far longer than glitch width
// [R05] no write with oe low or ce high
// [R06] program uses three unlock writes first
// [R07] erase uses six writes, sector or chip
// [R08] unlock guard always on, never bypassed
// [R09] device aborts bad sequence within read time
// [R10] id entry uses aa, 55, 90 writes
// [R11] id codes at address zero and one
// [R12] id exit by f0 alone or long
// [R13] id exit ignored while device busy
// [R14] device restarts in normal read mode
// [R15] only low fifteen address bits decoded
// [R16] sector chosen by top bits down to twelve
// [R17] device drives data only when selected
// [R18] write needs ce low, oe high, we low
// [R19] bit seven complements data while busy
// [R20] commands ignored while device busy
// [R21] address latched on fall, data on rise
// [R22] byte program finishes within 20 us
// [R23] array data returns after completion
`timescale 1ns/1ns
`default_nettype none
module pfcs_host
   import pfcs_pkg::*;
#(
   parameter int PROG_LIMIT = PFCS_PROG_CYC, // program poll limit, cycles
   parameter int ERASE_LIMIT = PFCS_ERASE_CYC // erase poll limit, cycles
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid, // start an operation
   input wire pfcs_pkg::pfcs_req_t req, // operation and operands
   output logic req_ready, // idle, request taken when valid
   output logic rsp_valid, // one-cycle completion pulse
   output pfcs_pkg::pfcs_rsp_t rsp, // read data and timeout flag
   output logic [18:0] flash_addr, // address pins
   input wire logic [7:0] flash_dq_i, // data pins in
   output logic [7:0] flash_dq_o, // data pins out
   output logic flash_dq_oe, // high while host drives data
   output logic flash_ce_n, // chip select
   output logic flash_oe_n, // output gate
   output logic flash_we_n // write strobe
);
   // ----------------------------------------
   // data pin synchroniser
   // ----------------------------------------
   logic [7:0] dq_s1_q, dq_s2_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dq_s1_q <= 8'h00;
         dq_s2_q <= 8'h00;
      end else begin
         dq_s1_q <= flash_dq_i;
         dq_s2_q <= dq_s1_q;
      end
   end

   // ----------------------------------------
   // sequence control
   // ----------------------------------------
   typedef enum logic [2:0] {PFCS_IDLE, PFCS_WRITE, PFCS_POLL1, PFCS_POLL2,
                             PFCS_READ, PFCS_DONE} pfcs_st_t;
   pfcs_st_t st_q;
   pfcs_req_t op_q; // held request
   logic [2:0] step_q; // write index within sequence
   logic [2:0] nsteps_q; // writes in this sequence
   logic [7:0] tog_q; // previous poll sample
   logic [31:0] wait_q; // poll cycle counter
   logic timeout_q;
   logic cyc_start_q, cyc_wr_q;
   pfcs_cyc_t cyc_q;
   logic cyc_done;
   logic [7:0] cyc_rdata;

   // write count per operation [R06] [R07] [R10] [R12]
   function automatic logic [2:0] seq_len(input pfcs_op_t op);
      unique case (op)
         PFCS_OP_PROG: seq_len = 3'd4;
         PFCS_OP_SECT, PFCS_OP_CHIP: seq_len = 3'd6;
         PFCS_OP_ID_ENTRY, PFCS_OP_ID_EXIT_LONG: seq_len = 3'd3;
         PFCS_OP_ID_EXIT: seq_len = 3'd1;
         default: seq_len = 3'd0;
      endcase
   endfunction

   // address and data of write n; upper unlock bits held at zero [R15]
   function automatic pfcs_cyc_t seq_word(input pfcs_req_t r, input logic [2:0] n);
      pfcs_cyc_t c;
      c.addr = {4'h0, (n == 3'd1 || n == 3'd4) ? PFCS_ADDR_B : PFCS_ADDR_A};
      c.data = (n == 3'd1 || n == 3'd4) ? PFCS_D_UNLOCK2 : PFCS_D_UNLOCK1;
      if (n == 3'd2) begin
         unique case (r.op)
            PFCS_OP_PROG: c.data = PFCS_D_PROG;
            PFCS_OP_SECT, PFCS_OP_CHIP: c.data = PFCS_D_ERASE;
            PFCS_OP_ID_ENTRY: c.data = PFCS_D_ID;
            default: c.data = PFCS_D_EXIT;
         endcase
      end
      if (r.op == PFCS_OP_PROG && n == 3'd3) begin
         c.addr = r.addr;
         c.data = r.data;
      end
      if (n == 3'd5) begin
         // sector from top_address_line down to bit twelve [R16]
         c.addr = (r.op == PFCS_OP_SECT) ? {r.addr[18:PFCS_SECT_LSB], 12'h000}
                                          : {4'h0, PFCS_ADDR_A};
         c.data = (r.op == PFCS_OP_SECT) ? PFCS_D_SECT : PFCS_D_CHIP;
      end
      if (r.op == PFCS_OP_ID_EXIT) begin
         c.addr = 19'h00000;
         c.data = PFCS_D_EXIT;
      end
      return c;
   endfunction

   wire last_write = (step_q == nsteps_q - 3'd1);
   wire busy_op = (op_q.op == PFCS_OP_PROG) || (op_q.op == PFCS_OP_SECT) ||
                  (op_q.op == PFCS_OP_CHIP);
   wire toggling = tog_q[PFCS_TOGGLE_BIT] != cyc_rdata[PFCS_TOGGLE_BIT];
   wire [31:0] limit = (op_q.op == PFCS_OP_PROG) ? 32'(PROG_LIMIT) : 32'(ERASE_LIMIT);
   wire poll_addr_sel = (op_q.op == PFCS_OP_PROG);
   wire [18:0] poll_addr = poll_addr_sel ? op_q.addr : 19'h00000;

   // operation sequencer; a new request is refused until done [R13] [R20]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= PFCS_IDLE;
         op_q <= '0;
         step_q <= 3'd0;
         nsteps_q <= 3'd0;
         tog_q <= 8'h00;
         wait_q <= 32'd0;
         timeout_q <= 1'b0;
         cyc_start_q <= 1'b0;
         cyc_wr_q <= 1'b0;
         cyc_q <= '0;
         req_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         cyc_start_q <= 1'b0;
         rsp_valid <= 1'b0;
         if (st_q != PFCS_IDLE && st_q != PFCS_DONE) wait_q <= wait_q + 32'd1;
         unique case (st_q)
            PFCS_IDLE: if (req_valid) begin
               op_q <= req;
               req_ready <= 1'b0;
               step_q <= 3'd0;
               nsteps_q <= seq_len(req.op);
               wait_q <= 32'd0;
               timeout_q <= 1'b0;
               cyc_start_q <= 1'b1;
               cyc_wr_q <= (req.op != PFCS_OP_READ);
               cyc_q <= (req.op == PFCS_OP_READ) ? pfcs_cyc_t'{addr: req.addr, data: 8'h00}
                                                 : seq_word(req, 3'd0);
               st_q <= (req.op == PFCS_OP_READ) ? PFCS_READ : PFCS_WRITE;
            end
            PFCS_WRITE: if (cyc_done) begin
               if (!last_write) begin
                  // full unlock prefix each time, guard is never skipped [R06] [R08]
                  step_q <= step_q + 3'd1;
                  cyc_start_q <= 1'b1;
                  cyc_q <= seq_word(op_q, step_q + 3'd1);
               end else if (busy_op) begin
                  // status valid after last strobe rose [R03]
                  st_q <= PFCS_POLL1;
                  wait_q <= 32'd0;
                  cyc_start_q <= 1'b1;
                  cyc_wr_q <= 1'b0;
                  cyc_q <= '{addr: poll_addr, data: 8'h00};
               end else
                  st_q <= PFCS_DONE;
            end
            PFCS_POLL1: if (cyc_done) begin
               tog_q <= cyc_rdata;
               st_q <= PFCS_POLL2;
               cyc_start_q <= 1'b1;
            end
            PFCS_POLL2: if (cyc_done) begin
               if (!toggling) begin
                  // toggle stopped: read true data [R02] [R19] [R23]
                  st_q <= PFCS_READ;
                  cyc_start_q <= 1'b1;
               end else if (wait_q >= limit) begin
                  // program or erase overran its poll limit; 20 us for program [R22]
                  timeout_q <= 1'b1;
                  st_q <= PFCS_DONE;
               end else begin
                  // still alternating, sample again [R01]
                  tog_q <= cyc_rdata;
                  cyc_start_q <= 1'b1;
               end
            end
            PFCS_READ: if (cyc_done) begin
               rsp.data <= cyc_rdata; // id codes at 0 and 1 [R11]
               st_q <= PFCS_DONE;
            end
            PFCS_DONE: begin
               rsp.timeout <= timeout_q;
               rsp_valid <= 1'b1;
               req_ready <= 1'b1;
               st_q <= PFCS_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // bus cycle engine
   // ----------------------------------------
   pfcs_cycle u_cycle (
      .clk(clk),
      .rst(rst),
      .start(cyc_start_q),
      .is_write(cyc_wr_q),
      .cyc(cyc_q),
      .dq_sync(dq_s2_q),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .addr_o(flash_addr),
      .dq_o(flash_dq_o),
      .dq_oe(flash_dq_oe),
      .ce_n(flash_ce_n),
      .oe_n(flash_oe_n),
      .we_n(flash_we_n)
   );

   // a zero limit would time out every poll at once; a negative one wraps to a huge unsigned limit and never times out
   if (PROG_LIMIT < 1 || ERASE_LIMIT < 1) begin : g_bad_limit
      $error("poll limits must be positive");
   end

   unlock_first_a: assert property (@(posedge clk) disable iff (rst) // [R06]
      (st_q == PFCS_WRITE && step_q == 3'd0 && op_q.op != PFCS_OP_ID_EXIT && cyc_start_q)
      |-> cyc_q.data == PFCS_D_UNLOCK1 && cyc_q.addr[14:0] == PFCS_ADDR_A)
      else $error("sequence not opened by unlock");
   unlock_second_a: assert property (@(posedge clk) disable iff (rst) // [R08]
      (st_q == PFCS_WRITE && step_q == 3'd1 && cyc_start_q)
      |-> cyc_q.data == PFCS_D_UNLOCK2 && cyc_q.addr[14:0] == PFCS_ADDR_B)
      else $error("second unlock wrong");
   erase_last_a: assert property (@(posedge clk) disable iff (rst) // [R07]
      (st_q == PFCS_WRITE && step_q == 3'd5 && cyc_start_q)
      |-> cyc_q.data == ((op_q.op == PFCS_OP_SECT) ? PFCS_D_SECT : PFCS_D_CHIP))
      else $error("erase command wrong");
   poll_after_a: assert property (@(posedge clk) disable iff (rst) // [R03]
      (st_q == PFCS_WRITE && cyc_done && last_write && busy_op) |=> st_q == PFCS_POLL1)
      else $error("no status poll after last write");
   stop_read_a: assert property (@(posedge clk) disable iff (rst) // [R02]
      (st_q == PFCS_POLL2 && cyc_done && !toggling) |=> st_q == PFCS_READ && cyc_start_q)
      else $error("toggle end missed");
   busy_block_a: assert property (@(posedge clk) disable iff (rst) // [R20]
      (st_q != PFCS_IDLE) |-> !req_ready)
      else $error("request taken while busy");
endmodule // pfcs_host
`default_nettype wire

/* hdl/pfcs_pkg.sv */
/*
 package for the parallel flash host controller: command codes, unlock
 addresses, bus timing counts, request and status carriers.
 assumes a 10 MHz system clock.
*/
package pfcs_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int PFCS_CLK_NS = 100; // clock period in ns
   localparam int PFCS_STROBE_NS = 200; // write strobe low width, ns
   localparam int PFCS_STROBE_CYC = (PFCS_STROBE_NS + PFCS_CLK_NS - 1) / PFCS_CLK_NS;
   localparam int PFCS_READ_NS = 200; // read access wait, covers read_cycle_time
   localparam int PFCS_READ_CYC = (PFCS_READ_NS + PFCS_CLK_NS - 1) / PFCS_CLK_NS;
   localparam int PFCS_PROG_US = 20; // longest byte program time
   localparam int PFCS_PROG_CYC = PFCS_PROG_US * 1000 / PFCS_CLK_NS;
   localparam int PFCS_ERASE_MS = 200; // poll give-up limit for erase, chosen
   localparam int PFCS_ERASE_CYC = PFCS_ERASE_MS * 10000;
   // ----------------------------------------
   // bus widths
   // ----------------------------------------
   localparam int PFCS_AW = 19; // address width, top_address_line is bit 18
   localparam int PFCS_CMD_AW = 15; // decoded low address bits
   localparam int PFCS_SECT_LSB = 12; // sector select starts at this bit
   // ----------------------------------------
   // unlock addresses and command data
   // ----------------------------------------
   localparam logic [14:0] PFCS_ADDR_A = 15'h5555;
   localparam logic [14:0] PFCS_ADDR_B = 15'h2aaa;
   localparam logic [7:0] PFCS_D_UNLOCK1 = 8'haa;
   localparam logic [7:0] PFCS_D_UNLOCK2 = 8'h55;
   localparam logic [7:0] PFCS_D_PROG = 8'ha0;
   localparam logic [7:0] PFCS_D_ERASE = 8'h80;
   localparam logic [7:0] PFCS_D_SECT = 8'h30;
   localparam logic [7:0] PFCS_D_CHIP = 8'h10;
   localparam logic [7:0] PFCS_D_ID = 8'h90;
   localparam logic [7:0] PFCS_D_EXIT = 8'hf0;
   localparam logic [18:0] PFCS_ID_MFR_ADDR = 19'h00000;
   localparam logic [18:0] PFCS_ID_DEV_ADDR = 19'h00001;
   localparam int PFCS_TOGGLE_BIT = 6; // alternating_status_bit position
   localparam int PFCS_POLL_BIT = 7; // complement_poll_bit position
   // ----------------------------------------
   // user operations and carriers
   // ----------------------------------------
   typedef enum logic [2:0] {
      PFCS_OP_READ, PFCS_OP_PROG, PFCS_OP_SECT, PFCS_OP_CHIP,
      PFCS_OP_ID_ENTRY, PFCS_OP_ID_EXIT, PFCS_OP_ID_EXIT_LONG
   } pfcs_op_t;
   typedef struct packed {
      pfcs_op_t op; // operation
      logic [18:0] addr; // byte, sector or id address
      logic [7:0] data; // program data
   } pfcs_req_t;
   typedef struct packed {
      logic [7:0] data; // read data
      logic timeout; // program or erase never finished
   } pfcs_rsp_t;
   typedef struct packed {
      logic [18:0] addr; // address pins
      logic [7:0] data; // data driven on a write
   } pfcs_cyc_t;
endpackage : pfcs_pkg

/* testbench/parallel_flash_command_status_test.sv */
/*
 self-checking bench for the flash host controller: table of operations,
 then reset, timeout and busy-ignore cases.
 assumes the flash model file is compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module parallel_flash_command_status_test;
   import pfcs_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam logic [7:0] MFR_CODE = 8'h3e; // arbitrary value
   localparam logic [7:0] DEV_CODE = 8'h4d; // arbitrary value
   logic clk, rst, req_valid, req_ready, rsp_valid;
   pfcs_req_t req;
   pfcs_rsp_t rsp;
   logic [18:0] flash_addr;
   logic [7:0] flash_dq_i, host_o, dev_o, dq_last;
   logic flash_dq_oe, dev_oe, flash_ce_n, flash_oe_n, flash_we_n;
   logic [31:0] busy_ns;
   int failures = 0;
   int checks_done = 0;
   // pins and handshake that reset must park
   wire [5:0] park_pins = {flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, req_ready, rsp_valid};
   // released wire shows the inverse of its last value
   assign flash_dq_i = flash_dq_oe ? host_o : dev_oe ? dev_o : ~dq_last;
   always @(posedge clk) if (flash_dq_oe || dev_oe) dq_last <= flash_dq_i;
   initial dq_last = 8'h00;
   pfcs_host #(.PROG_LIMIT(200), .ERASE_LIMIT(400)) i_dut (
      .clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp(rsp), .flash_addr(flash_addr), .flash_dq_i(flash_dq_i),
      .flash_dq_o(host_o), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
      .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
   pfcs_flash_model #(.MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE)) i_flash (
      .addr(flash_addr), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
      .dq_i(flash_dq_i), .busy_ns(busy_ns), .dq_o(dev_o), .dq_oe(dev_oe));
   initial clk = 1'b0;
   always #50 clk = ~clk;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic complete_run();
      if (failures == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      checks_done++;
      if (seen !== want) begin
         failures++;
         $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask
   task automatic do_op(input pfcs_op_t op, input logic [18:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{op, a, d};
      n = 0;
      do @(negedge clk); while (req_ready !== 1'b1 && ++n < 100);
      if (n >= 100) check(32'h0, 32'h1, "never ready");
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 5000);
      if (n >= 5000) check(32'h0, 32'h1, "no response");
   endtask
   // pin relations watched every cycle
   always @(negedge clk) begin
      if (!rst && !flash_we_n) check({flash_ce_n, flash_oe_n}, 2'b01, "write pins");
   end
   always @(negedge clk) if (!flash_oe_n) check(flash_dq_oe, 1'b0, "bus contention");
   // ----------------------------------------
   // operation table
   // ----------------------------------------
   typedef struct {pfcs_op_t op; logic [18:0] a; logic [7:0] d;
                   logic chk; logic [7:0] exp;} pfcs_row_t;
   pfcs_row_t rows [18] = '{
      '{PFCS_OP_READ, 19'h00100, 8'h00, 1'b1, 8'hff},
      '{PFCS_OP_PROG, 19'h00100, 8'h3c, 1'b1, 8'h3c},
      '{PFCS_OP_READ, 19'h00100, 8'h00, 1'b1, 8'h3c},
      '{PFCS_OP_PROG, 19'h41234, 8'h5a, 1'b1, 8'h5a},
      '{PFCS_OP_PROG, 19'h41234, 8'h0f, 1'b1, 8'h0a},
      '{PFCS_OP_ID_ENTRY, 19'h00000, 8'h00, 1'b0, 8'h00},
      '{PFCS_OP_READ, 19'h00000, 8'h00, 1'b1, MFR_CODE},
      '{PFCS_OP_READ, 19'h00001, 8'h00, 1'b1, DEV_CODE},
      '{PFCS_OP_ID_EXIT, 19'h00000, 8'h00, 1'b0, 8'h00},
      '{PFCS_OP_READ, 19'h00001, 8'h00, 1'b1, 8'hff},
      '{PFCS_OP_ID_ENTRY, 19'h00000, 8'h00, 1'b0, 8'h00},
      '{PFCS_OP_ID_EXIT_LONG, 19'h00000, 8'h00, 1'b0, 8'h00},
      '{PFCS_OP_READ, 19'h00000, 8'h00, 1'b1, 8'hff},
      '{PFCS_OP_SECT, 19'h41000, 8'h00, 1'b1, 8'hff},
      '{PFCS_OP_READ, 19'h41234, 8'h00, 1'b1, 8'hff},
      '{PFCS_OP_READ, 19'h00100, 8'h00, 1'b1, 8'h3c},
      '{PFCS_OP_CHIP, 19'h00000, 8'h00, 1'b1, 8'hff},
      '{PFCS_OP_READ, 19'h00100, 8'h00, 1'b1, 8'hff}};
   // watchdog sized well above the whole run
   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      complete_run();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      req_valid = 1'b0;
      req = '0;
      busy_ns = 2000;
      rst = 1'b1;
      repeat (9) @(posedge clk);
      @(negedge clk);
      check(park_pins, 6'b111010, "reset pins");
      @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         do_op(rows[i].op, rows[i].a, rows[i].d);
         check(rsp.timeout, 1'b0, "timeout flag");
         if (rows[i].chk) check(rsp.data, rows[i].exp, "response data");
      end
      // reset in mid read: pins park at once, the next read still works
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{PFCS_OP_READ, 19'h00100, 8'h00};
      repeat (4) @(posedge clk);
      req_valid <= 1'b0;
      rst <= 1'b1;
      @(negedge clk);
      check(park_pins, 6'b111010, "mid reset pins");
      @(posedge clk);
      rst <= 1'b0;
      do_op(PFCS_OP_READ, 19'h00100, 8'h00);
      check(rsp.data, 8'hff, "read after reset");
      // slow device: program overruns the poll limit
      busy_ns <= 100000;
      do_op(PFCS_OP_PROG, 19'h00200, 8'h81);
      check(rsp.timeout, 1'b1, "slow program");
      // still busy: this program must be ignored
      do_op(PFCS_OP_PROG, 19'h00300, 8'h00);
      check(rsp.timeout, 1'b1, "busy program");
      repeat (1100) @(posedge clk);
      busy_ns <= 2000;
      do_op(PFCS_OP_READ, 19'h00200, 8'h00);
      check(rsp.data, 8'h81, "late program data");
      do_op(PFCS_OP_READ, 19'h00300, 8'h00);
      check(rsp.data, 8'hff, "ignored program");
      complete_run();
   end
endmodule // parallel_flash_command_status_test
`default_nettype wire

/* testbench/pfcs_flash_model.sv */
/*
 behavioural byte-wide flash: unlock sequences, toggle and complement status,
 id mode, sector and chip erase, write inhibit and glitch filter.
 assumes the bench resolves the shared data wire and feeds it to dq_i.
*/
`timescale 1ns/1ns
`default_nettype none
module pfcs_flash_model #(
   parameter logic [7:0] MFR_CODE = 8'h3e, // arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h4d // arbitrary value
)(
   input wire logic [18:0] addr,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [7:0] dq_i,
   input wire logic [31:0] busy_ns, // internal operation length
   output logic [7:0] dq_o,
   output logic dq_oe
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] mem [int]; // absent key reads erased
   logic [18:0] lat_a; // latched address
   time t_fall; // start of write pulse
   int step; // unlock progress
   logic id_mode, busy, toggle, is_prog;
   logic [7:0] prog_d; // byte being programmed
   wire wr = !ce_n && !we_n;
   wire rd = !ce_n && !oe_n && we_n;
   wire ua = lat_a[14:0] == 15'h5555;
   wire ub = lat_a[14:0] == 15'h2aaa;
   initial begin
      step = 0;
      id_mode = 0;
      busy = 0;
      toggle = 0;
      is_prog = 0;
      prog_d = 8'h00;
      lat_a = 19'h00000;
      t_fall = 0;
   end
   function automatic logic [7:0] mem_rd(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 8'hff;
   endfunction
   task automatic erase(input logic [6:0] s, input logic all);
      int keys[$];
      foreach (mem[k]) if (all || k[18:12] == s) keys.push_back(k);
      foreach (keys[i]) mem.delete(keys[i]);
      is_prog = 0;
      busy = 1;
   endtask
   // ----------------------------------------
   // command decode, guard always on
   // ----------------------------------------
   task automatic take(input logic [7:0] d);
      case (step)
         1: step = (ub && d == 8'h55) ? 2 : 0;
         2: begin
            step = (ua && d == 8'ha0) ? 3 : (ua && d == 8'h80) ? 4 : 0;
            if (ua && d == 8'h90) id_mode = 1;
            if (ua && d == 8'hf0) id_mode = 0;
         end
         3: begin
            step = 0;
            prog_d = mem_rd(lat_a) & d;
            mem[lat_a] = prog_d;
            is_prog = 1;
            busy = 1;
         end
         4: step = (ua && d == 8'haa) ? 5 : 0;
         5: step = (ub && d == 8'h55) ? 6 : 0;
         6: begin
            step = 0;
            if (d == 8'h30) erase(lat_a[18:12], 1'b0);
            if (ua && d == 8'h10) erase(7'h00, 1'b1);
         end
         default: begin
            step = (ua && d == 8'haa) ? 1 : 0;
            if (d == 8'hf0) id_mode = 0;
         end
      endcase
   endtask
   // address on later fall, data on earlier rise
   always @(posedge wr) begin
      lat_a = addr;
      t_fall = $time;
   end
   // strobe end takes data; short, gated or busy writes are dropped
   always @(negedge wr) begin
      if (oe_n && $time - t_fall >= 5 && !busy) take(dq_i);
   end
   // internal operation end
   always @(posedge busy) begin
      #(busy_ns);
      busy = 0;
   end
   // toggle flips on each read while busy
   always @(posedge rd) if (busy) toggle = !toggle;
   // ----------------------------------------
   // read path
   // ----------------------------------------
   assign dq_oe = rd;
   always @(addr or rd or busy or toggle or id_mode) begin
      if (busy) dq_o = {is_prog ? ~prog_d[7] : 1'b0, toggle, 6'h2a};
      else if (id_mode && addr[18:1] == 18'h0) dq_o = addr[0] ? DEV_CODE : MFR_CODE;
      else dq_o = mem_rd(addr);
   end
endmodule // pfcs_flash_model
`default_nettype wire
